// File: rtl/tifd_defines.svh
// constants of the terminal input fan-in decoder: offsets, fields, counts
// assumes inclusion by its bare name from every file that needs them
`ifndef TIFD_DEFINES_SVH
`define TIFD_DEFINES_SVH

// ****************************************************************
// register byte offsets on the apb side
// ****************************************************************
`define TIFD_OFF_CONNECT   12'h000
`define TIFD_OFF_WORD      12'h004
`define TIFD_OFF_STATUS    12'h008

// ****************************************************************
// connect register fields
// ****************************************************************
`define TIFD_CON_CODE_HI   11
`define TIFD_CON_STROBE    12
`define TIFD_CON_SCAN      13
`define TIFD_CON_CLEAR     14

// ****************************************************************
// connect code fields (four octal digits)
// ****************************************************************
`define TIFD_CODE_SYS_HI   11
`define TIFD_CODE_SYS_LO   9
`define TIFD_CODE_GRP_HI   8
`define TIFD_CODE_GRP_LO   6
`define TIFD_CODE_CAB_HI   5
`define TIFD_CODE_CAB_LO   4
`define TIFD_CODE_SECT     3
`define TIFD_CODE_UNIT_HI  2
`define TIFD_CODE_STRAP_LO 3
`define TIFD_SYS_VALUE     3'h0
`define TIFD_GROUP_MAX     3'h2

// ****************************************************************
// returned word and status fields
// ****************************************************************
`define TIFD_W_DATA_HI     7
`define TIFD_W_BRKIDLE     9
`define TIFD_W_LOST        10
`define TIFD_W_READY       11
`define TIFD_W_REPLY       12
`define TIFD_S_MATCH       0
`define TIFD_S_IDX_LO      1
`define TIFD_S_IDX_HI      3
`define TIFD_S_SECT        4
`define TIFD_S_SYSOK       5
`define TIFD_S_SCAN        6
`define TIFD_S_OUTREQ      7
`define TIFD_S_PEND_LO     8
`define TIFD_S_PEND_HI     15

// ****************************************************************
// sizes and timing
// ****************************************************************
`define TIFD_MAX_UNITS     8
`define TIFD_MAX_DATA      8
`define TIFD_STRAP_W       9
`define TIFD_STRAP_SETTLE  2'h3
`define TIFD_IDLE_SEC      5
`define TIFD_CLK_HZ        50000000
`define TIFD_IDLE_CNT_W    32

`endif

// File: rtl/tifd_pkg.sv
// state types of the terminal input fan-in decoder
// assumes tifd_defines.svh for the field widths
`include "tifd_defines.svh"

package tifd_pkg;

   // ****************************************************************
   // per unit status holder state
   // ****************************************************************
   typedef struct packed {
      logic [`TIFD_MAX_DATA-1:0]   hold;
      logic                        ready;
      logic                        lost;
      logic                        brk;
      logic                        idle;
      logic                        strb_prev;
      logic [`TIFD_IDLE_CNT_W-1:0] cnt;
   } tifd_unit_state_t;

   // ****************************************************************
   // top level state
   // ****************************************************************
   typedef struct packed {
      logic [11:0]                code;
      logic                       conn;
      logic                       scan;
      logic [2:0]                 idx;
      logic [`TIFD_MAX_UNITS-1:0] ack;
      logic                       clr;
      logic [31:0]                rdata;
      logic                       pready;
      logic                       slverr;
      logic [`TIFD_STRAP_W-1:0]   strap;
      logic [1:0]                 strap_cnt;
   } tifd_top_state_t;

endpackage : tifd_pkg

// File: rtl/tifd_sync.sv
// two flip-flop synchroniser for a bundle of pin levels
// assumes the levels are slow against clk; words must be stable around use
`timescale 1ns/1ps

module tifd_sync #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         resetn,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tifd_sync_state_t;

   tifd_sync_state_t st_q;
   tifd_sync_state_t st_d;

   // first stage feeds only the second
   always_comb
   begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;

endmodule : tifd_sync

// File: rtl/tifd_unit_status.sv
// status holder for one serial_input_unit: holding register and four flags
// assumes synchronised inputs and a one-cycle acknowledge from the fan-in
`timescale 1ns/1ps
`include "tifd_defines.svh"

module tifd_unit_status #(
   parameter int DATA_W      = `TIFD_MAX_DATA,
   parameter int IDLE_CYCLES = `TIFD_IDLE_SEC * `TIFD_CLK_HZ
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              clr,
   // unit side levels
   input  wire logic [DATA_W-1:0] char_in,
   input  wire logic              strobe,
   input  wire logic              brk_line,
   input  wire logic              marking,
   input  wire logic              ack,
   // fan-in side
   output logic      [DATA_W-1:0] data,
   output logic                   ready,
   output logic                   lost,
   output logic                   brk_idle
);

   tifd_pkg::tifd_unit_state_t st_q;
   tifd_pkg::tifd_unit_state_t st_d;
   logic                       new_char;

   assign new_char = strobe & ~st_q.strb_prev;

   // holding register and idle timer are sized for these ranges
   generate
      if (DATA_W < 1 || DATA_W > `TIFD_MAX_DATA || IDLE_CYCLES < 1)
      begin : g_bad_param
         $error("DATA_W or IDLE_CYCLES out of range");
      end
   endgenerate

   // flag update; the ready and break sets win over the acknowledge clear
   always_comb
   begin
      st_d           = st_q;
      st_d.strb_prev = strobe;
      if (new_char)
      begin
         st_d.hold  = `TIFD_MAX_DATA'(char_in);
         st_d.ready = 1'b1;
      end
      else if (ack)
      begin
         st_d.ready = 1'b0;
      end
      if (ack)
      begin
         st_d.lost = 1'b0;
         st_d.brk  = 1'b0;
      end
      if (new_char && st_q.ready && !ack)
      begin
         st_d.lost = 1'b1;
      end
      if (brk_line)
      begin
         st_d.brk = 1'b1;
      end
      // idle timer runs while the line stays marking
      if (!marking)
      begin
         st_d.cnt  = '0;
         st_d.idle = 1'b0;
      end
      else if (st_q.cnt == `TIFD_IDLE_CNT_W'(IDLE_CYCLES - 1))
      begin
         st_d.idle = 1'b1;
      end
      else
      begin
         st_d.cnt = st_q.cnt + `TIFD_IDLE_CNT_W'(1);
      end
      if (clr)
      begin
         st_d       = '0;
         st_d.hold  = st_q.hold;
         st_d.strb_prev = strobe;
      end
   end

   // state register
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // break forces an all-zero character; idle keeps the held one
   assign data     = st_q.brk ? '0 : st_q.hold[DATA_W-1:0];
   assign ready    = st_q.ready;
   assign lost     = st_q.lost;
   assign brk_idle = st_q.brk | st_q.idle;

endmodule : tifd_unit_status

// File: rtl/tifd_top.sv
// terminal input fan-in decoder: connect-code decode, unit fan-in, apb slave
// assumes an apb master on clk; unit pins and strap arrive asynchronously
// one instance serves one section; a cabinet fits two
// every apb transfer gets exactly one wait state
// connect at 0x000, word at 0x004, status at 0x008
`timescale 1ns/1ps
`include "tifd_defines.svh"

module tifd_top #(
   parameter int NUM_UNITS   = `TIFD_MAX_UNITS,
   parameter int DATA_W      = `TIFD_MAX_DATA,
   parameter int IDLE_CYCLES = `TIFD_IDLE_SEC * `TIFD_CLK_HZ
) (
   // clock and reset
   input  wire logic                        clk,
   input  wire logic                        resetn,
   // apb slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   // cabinet and section strap
   input  wire logic [`TIFD_STRAP_W-1:0]    strap_code,
   // serial_input_unit side
   input  wire logic [NUM_UNITS*DATA_W-1:0] unit_char,
   input  wire logic [NUM_UNITS-1:0]        unit_strobe,
   input  wire logic [NUM_UNITS-1:0]        unit_break,
   input  wire logic [NUM_UNITS-1:0]        unit_mark,
   output logic      [NUM_UNITS-1:0]        unit_ack,
   // serial_output_unit character requests
   input  wire logic [NUM_UNITS-1:0]        out_req
);

   // ****************************************************************
   // elaboration checks
   // ****************************************************************
   // bits of pin levels passing the synchroniser
   localparam int SW = NUM_UNITS * (DATA_W + 4) + `TIFD_STRAP_W;

   // the index and the state fields are sized for eight units of eight bits
   generate
      if (NUM_UNITS < 1 || NUM_UNITS > `TIFD_MAX_UNITS)
      begin : g_bad_units
         $error("NUM_UNITS must lie between 1 and 8");
      end
      // word holds at most eight data bits
      if (DATA_W < 1 || DATA_W > `TIFD_MAX_DATA)
      begin : g_bad_data
         $error("DATA_W must lie between 1 and 8");
      end
      // idle timer needs at least one cycle
      if (IDLE_CYCLES < 1)
      begin : g_bad_idle
         $error("IDLE_CYCLES must be at least 1");
      end
   endgenerate

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [SW-1:0]                  sync_q;
   logic [`TIFD_STRAP_W-1:0]       s_strap;
   logic [NUM_UNITS-1:0]           s_outreq;
   logic [NUM_UNITS-1:0]           s_mark;
   logic [NUM_UNITS-1:0]           s_brk;
   logic [NUM_UNITS-1:0]           s_strobe;
   logic [NUM_UNITS*DATA_W-1:0]    s_char;

   // characters settle a cycle before their strobe rises,
   // so word and strobe may share one synchroniser
   tifd_sync #(
      .W      (SW)
   ) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({strap_code, out_req, unit_mark, unit_break, unit_strobe, unit_char}),
      .q      (sync_q)
   );

   // split the synchronised bundle
   // order follows the concatenation at the input
   assign {s_strap, s_outreq, s_mark, s_brk, s_strobe, s_char} = sync_q;

   // ****************************************************************
   // state
   // ****************************************************************
   // one packed struct holds every register
   tifd_pkg::tifd_top_state_t st_q;
   tifd_pkg::tifd_top_state_t st_d;

   // flags and characters of every unit
   logic [NUM_UNITS-1:0]  u_ready;
   logic [NUM_UNITS-1:0]  u_lost;
   logic [NUM_UNITS-1:0]  u_brkidle;
   logic [DATA_W-1:0]     u_data [NUM_UNITS];

   // ****************************************************************
   // per unit status holders
   // ****************************************************************
   // one holder per fitted unit, each with its own ack
   genvar gi;
   generate
      for (gi = 0; gi < NUM_UNITS; gi++)
      begin : g_unit
         tifd_unit_status #(
            .DATA_W      (DATA_W),
            .IDLE_CYCLES (IDLE_CYCLES)
         ) u_stat (
            .clk         (clk),
            .resetn      (resetn),
            .clr         (st_q.clr),
            .char_in     (s_char[gi*DATA_W +: DATA_W]),
            .strobe      (s_strobe[gi]),
            .brk_line    (s_brk[gi]),
            .marking     (s_mark[gi]),
            .ack         (st_q.ack[gi]),
            .data        (u_data[gi]),
            .ready       (u_ready[gi]),
            .lost        (u_lost[gi]),
            .brk_idle    (u_brkidle[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // connect code decode
   // ****************************************************************
   logic        sys_ok;
   logic        match;
   logic        sel_in;
   logic        sel_ready;
   logic [11:0] word;
   logic [11:0] unit_word;

   // system digit zero and group digit at most two
   // codes above group two reach no cabinet here
   assign sys_ok = (st_q.code[`TIFD_CODE_SYS_HI:`TIFD_CODE_SYS_LO] == `TIFD_SYS_VALUE)
                 && (st_q.code[`TIFD_CODE_GRP_HI:`TIFD_CODE_GRP_LO] <= `TIFD_GROUP_MAX);

   // no match until the strap has settled after reset
   // system, group, cabinet and section digits compared whole against the strap
   assign match = st_q.conn && sys_ok
                && (st_q.code[`TIFD_CODE_SYS_HI:`TIFD_CODE_STRAP_LO] == st_q.strap)
                && (st_q.strap_cnt == `TIFD_STRAP_SETTLE);

   // index must name a fitted unit
   // so a short section never reads a missing unit
   assign sel_in    = (32'(st_q.idx) < NUM_UNITS);
   assign sel_ready = match && sel_in && u_ready[st_q.idx];

   // ****************************************************************
   // fan-in of the selected unit onto the shared word
   // ****************************************************************
   always_comb
   begin
      // unmatched or unfitted selections read zero
      unit_word = '0;
      if (match && sel_in)
      begin
         unit_word[`TIFD_W_DATA_HI:0] = `TIFD_MAX_DATA'(u_data[st_q.idx]);
         unit_word[`TIFD_W_READY]     = u_ready[st_q.idx];
         unit_word[`TIFD_W_LOST]      = u_lost[st_q.idx];
         unit_word[`TIFD_W_BRKIDLE]   = u_brkidle[st_q.idx];
      end
      word = unit_word;
   end

   // ****************************************************************
   // apb decode helpers
   // ****************************************************************
   logic apb_first;
   logic apb_done;
   logic mapped;

   // pready low marks the first access cycle
   assign apb_first = psel && penable && !st_q.pready;
   assign apb_done  = psel && penable && st_q.pready;
   assign mapped    = (paddr == `TIFD_OFF_CONNECT) || (paddr == `TIFD_OFF_WORD)
                   || (paddr == `TIFD_OFF_STATUS);

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      // pulses and the answer stand one cycle only
      st_d        = st_q;
      st_d.ack    = '0;
      st_d.clr    = 1'b0;
      st_d.pready = 1'b0;

      // strap caught over the first cycles after release
      // later changes wait for the next reset
      if (st_q.strap_cnt != `TIFD_STRAP_SETTLE)
      begin
         st_d.strap     = s_strap;
         st_d.strap_cnt = st_q.strap_cnt + 2'h1;
      end

      // first access cycle: prepare the answer, wait state of one cycle
      // a unit turning ready later shows on the next read
      if (apb_first)
      begin
         st_d.pready = 1'b1;
         // unmapped offsets answer error and zero data
         st_d.slverr = !mapped;
         st_d.rdata  = '0;
         case (paddr)
            // clear is write only and reads zero
            `TIFD_OFF_CONNECT:
            begin
               st_d.rdata[`TIFD_CON_CODE_HI:0] = st_q.code;
               st_d.rdata[`TIFD_CON_STROBE]    = st_q.conn;
               st_d.rdata[`TIFD_CON_SCAN]      = st_q.scan;
            end
            // reply only while the selected unit is ready
            `TIFD_OFF_WORD:
            begin
               st_d.rdata[11:0]          = word;
               st_d.rdata[`TIFD_W_REPLY] = sel_ready;
            end
            // decode as the host sees it
            `TIFD_OFF_STATUS:
            begin
               st_d.rdata[`TIFD_S_MATCH]                  = match;
               st_d.rdata[`TIFD_S_IDX_HI:`TIFD_S_IDX_LO]  = st_q.idx;
               st_d.rdata[`TIFD_S_SECT]                   = st_q.code[`TIFD_CODE_SECT];
               st_d.rdata[`TIFD_S_SYSOK]                  = sys_ok;
               st_d.rdata[`TIFD_S_SCAN]                   = st_q.scan;
               st_d.rdata[`TIFD_S_OUTREQ]                 = match && (|s_outreq);
               st_d.rdata[`TIFD_S_PEND_HI:`TIFD_S_PEND_LO] = `TIFD_MAX_UNITS'(u_ready);
            end
            default:
            begin
               st_d.rdata = '0;
            end
         endcase
      end

      // completing edge: writes land, reads of a replied word accept it
      // a read without reply leaves the flags alone
      if (apb_done)
      begin
         st_d.rdata  = '0;
         st_d.slverr = 1'b0;
         // only connect takes writes
         if (pwrite && paddr == `TIFD_OFF_CONNECT)
         begin
            st_d.code = pwdata[`TIFD_CON_CODE_HI:0];
            st_d.conn = pwdata[`TIFD_CON_STROBE];
            st_d.scan = pwdata[`TIFD_CON_SCAN];
            // in scan mode the scanner owns the index
            if (!pwdata[`TIFD_CON_SCAN])
            begin
               st_d.idx = pwdata[`TIFD_CODE_UNIT_HI:0];
            end
            // clear overrides the fields written with it
            if (pwdata[`TIFD_CON_CLEAR])
            begin
               st_d.clr  = 1'b1;
               st_d.code = '0;
               st_d.conn = 1'b0;
               st_d.scan = 1'b0;
               st_d.idx  = '0;
            end
         end
         else if (!pwrite && paddr == `TIFD_OFF_WORD && st_q.rdata[`TIFD_W_REPLY])
         begin
            st_d.ack = `TIFD_MAX_UNITS'(1) << st_q.idx;
         end
      end

      // scanner walks the units until one holds a character
      // frozen during transfers so a read sees one index
      if (st_q.scan && match && !psel && !sel_ready && !st_q.clr)
      begin
         // wrap after the last fitted unit
         if (32'(st_q.idx) >= NUM_UNITS - 1)
         begin
            st_d.idx = '0;
         end
         else
         begin
            st_d.idx = st_q.idx + 3'h1;
         end
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // all state cleared together by reset
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs straight from state
   // ack cut to the fitted units
   assign prdata   = st_q.rdata;
   assign pready   = st_q.pready;
   assign pslverr  = st_q.slverr;
   assign unit_ack = st_q.ack[NUM_UNITS-1:0];

endmodule : tifd_top

// File: bench/tifd_unit_model.sv
// partner model of eight serial_input_unit devices feeding the fan-in
// assumes its tasks are called by the bench just after a rising clk edge
`timescale 1ns/1ps

module tifd_unit_model (
   // clock
   input  wire logic        clk,
   // unit pins
   output logic      [63:0] unit_char,
   output logic      [7:0]  unit_strobe,
   output logic      [7:0]  unit_break,
   output logic      [7:0]  unit_mark,
   input  wire logic [7:0]  unit_ack
);
   int n_ack [8];

   // quiet lines at time zero: spacing, no break, no character
   initial
   begin
      unit_char = 64'h0;
      unit_strobe = 8'h0;
      unit_break = 8'h0;
      unit_mark = 8'h0;
   end

   // tally acknowledges, the only signal that reaches a unit
   always @(posedge clk)
      for (int i = 0; i < 8; i++)
         if (unit_ack[i] === 1'b1)
            n_ack[i]++;

   // present a character, then a rising strobe held four cycles
   task send(input int u, input logic [7:0] c);
      unit_char[u*8 +: 8] <= c;
      @(posedge clk);
      unit_strobe[u] <= 1'b1;
      repeat (4) @(posedge clk);
      unit_strobe[u] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : send

   // set break and marking levels of one unit
   task lines(input int u, input logic b, input logic m);
      unit_break[u] <= b;
      unit_mark[u] <= m;
   endtask : lines
endmodule : tifd_unit_model

// File: bench/tifd_checker.sv
// concurrent checks on the ports of the fan-in decoder top
// assumes one clk domain and the bind at the foot of this file
`timescale 1ns/1ps

module tifd_checker #(
   parameter int NUM_UNITS = 8
) (
   // clock, reset and apb
   input wire logic                 clk,
   input wire logic                 resetn,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   // unit side
   input wire logic [NUM_UNITS-1:0] unit_ack
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   // ****************************************************************
   // transfer phases
   // ****************************************************************
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   sequence s_wread; pready && psel && !pwrite && paddr == 12'h004; endsequence

   property p_ack_onehot; $onehot0(unit_ack); endproperty
   property p_ack_pulse; unit_ack != 0 |=> unit_ack == 0; endproperty
   property p_ack_cause; (s_wread ##0 prdata[12]) |=> $onehot(unit_ack); endproperty
   property p_ack_only;
      unit_ack != 0 |-> $past(pready && !pwrite && paddr == 12'h004 && prdata[12]);
   endproperty
   property p_reply; s_wread |-> prdata[12] == prdata[11]; endproperty
   property p_width; s_wread |-> prdata[31:13] == 19'h0 && !prdata[8]; endproperty
   property p_released; !pready |-> prdata == 32'h0; endproperty
   property p_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
   property p_unmapped; pready && paddr > 12'h008 |-> pslverr && prdata == 32'h0; endproperty

   a_ack_onehot: assert property (p_ack_onehot) else $error("ack not one-hot");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   a_ack_cause: assert property (p_ack_cause) else $error("ack missing");
   a_ack_only: assert property (p_ack_only) else $error("ack uncaused");
   a_reply: assert property (p_reply) else $error("reply without ready");
   a_width: assert property (p_width) else $error("word too wide");
   a_released: assert property (p_released) else $error("lines not released");
   a_wait: assert property (p_wait) else $error("answer late");
   a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
endmodule : tifd_checker

bind tifd_top tifd_checker #(.NUM_UNITS(NUM_UNITS)) u_chk (.clk(clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .unit_ack(unit_ack));

// File: bench/tifd_tb_top.sv
// self-checking bench of the fan-in decoder with apb master and unit model
// assumes idle time shortened to twenty cycles
`timescale 1ns/1ps

module tifd_tb_top;
   logic        clk, resetn, psel, penable, pwrite, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic        pready, pslverr;
   logic [8:0]  strap_code;
   logic [8:0]  bad [4];
   logic [63:0] unit_char;
   logic [7:0]  unit_strobe, unit_break, unit_mark, unit_ack, out_req, c;
   int          n_mismatch, num_checks, seed, u, k;

   tifd_top #(.IDLE_CYCLES(20)) dut (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .strap_code(strap_code), .unit_char(unit_char),
      .unit_strobe(unit_strobe), .unit_break(unit_break), .unit_mark(unit_mark),
      .unit_ack(unit_ack), .out_req(out_req));
   tifd_unit_model um (.clk(clk), .unit_char(unit_char), .unit_strobe(unit_strobe),
      .unit_break(unit_break), .unit_mark(unit_mark), .unit_ack(unit_ack));

   // 50 mhz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ****************************************************************
   // helpers
   // ****************************************************************
   task stop_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task chk(input logic [31:0] g, input logic [31:0] x);
      num_checks++;
      if (g !== x)
      begin
         n_mismatch++;
         $display("unexpected at %0t got %h exp %h", $time, g, x);
      end
   endtask : chk

   // one apb transfer; request held until pready is seen high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      k = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 40);
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         stop_test();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(r & m, x);
   endtask : rd

   // connect word with strobe for one unit of our strap
   function automatic logic [31:0] cc(input int n);
      return {19'h0, 1'b1, strap_code, 3'(n)};
   endfunction : cc

   // word of a ready unit: reply, ready, lost, break/idle, zero, data
   function automatic logic [31:0] wexp(input logic [7:0] d, input logic l);
      return {19'h0, 2'b11, l, 2'b00, d};
   endfunction : wexp

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      seed = 11;
      {resetn, psel, penable, pwrite, paddr, pwdata} <= '0;
      strap_code <= {3'h0, 3'($unsigned($random(seed)) % 3), 3'($random(seed))};
      out_req <= 8'($random(seed)) | 8'h01;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      for (u = 0; u < 8; u++)
      begin
         c = 8'($random(seed));
         um.send(u, c);
         apb(1'b1, 12'h000, cc(u));
         rd(12'h004, 32'hffffffff, wexp(c, 1'b0));
         rd(12'h004, 32'h1e00, 32'h0);
         chk(32'(um.n_ack[u]), 32'h1);
      end
      u = $unsigned($random(seed)) % 8;
      um.send(u, c);
      um.send(u, ~c);
      apb(1'b1, 12'h000, cc(u));
      rd(12'h004, 32'h1e00, 32'h1c00);
      rd(12'h004, 32'h1e00, 32'h0);
      um.send(u, c);
      bad[0] = strap_code ^ 9'h001;
      bad[1] = strap_code ^ 9'h004;
      bad[2] = {strap_code[8:6], 3'h3, strap_code[2:0]};
      bad[3] = strap_code | 9'h040;
      for (int j = 0; j < 4; j++)
      begin
         apb(1'b1, 12'h000, {19'h0, 1'b1, bad[j], 3'(u)});
         rd(12'h004, 32'hffffffff, 32'h0);
      end
      apb(1'b1, 12'h000, cc(u) & 32'hfff);
      rd(12'h004, 32'hffffffff, 32'h0);
      apb(1'b1, 12'h000, cc(u));
      rd(12'h004, 32'hffffffff, wexp(c, 1'b0));
      um.lines(u, 1'b1, 1'b0);
      repeat (8) @(posedge clk);
      rd(12'h004, 32'h2ff, 32'h200);
      um.lines(u, 1'b0, 1'b0);
      apb(1'b1, 12'h000, 32'h4000);
      rd(12'h004, 32'hffffffff, 32'h0);
      apb(1'b1, 12'h000, cc(u));
      um.lines(u, 1'b0, 1'b1);
      repeat (30) @(posedge clk);
      rd(12'h004, 32'h2ff, {22'h0, 2'b10, c});
      um.lines(u, 1'b0, 1'b0);
      repeat (6) @(posedge clk);
      rd(12'h004, 32'h200, 32'h0);
      u = $unsigned($random(seed)) % 8;
      um.send(u, c);
      apb(1'b1, 12'h000, cc(0) | 32'h2000);
      repeat (12) @(posedge clk);
      rd(12'h008, 32'hcf, 32'hc1 | (u << 1));
      rd(12'h004, 32'hffffffff, wexp(c, 1'b0));
      apb(1'b0, 12'h00c, 32'h0);
      chk({e, r[30:0]}, 32'h80000000);
      stop_test();
   end
endmodule : tifd_tb_top
